// ===== rtl/pin_driver_mode_control.sv
// Quad pin driver mode control: serial port, channel latches, output select
module pin_driver_mode_control
  import pin_driver_pkg::*;
#(
  parameter int NUM_CH = `CHAN_COUNT,
  parameter bit STRICT_LENGTH = 1'b0,
  parameter int APPLY_COUNT_W = 16
) (
  input wire logic clock, // System clock, 125 MHz
  input wire logic rst_n, // Reset, active low, asynchronous
  input wire logic por_n, // Power-up reset, active low, asynchronous
  input wire logic serial_clock, // Serial port clock from controller
  input wire logic select_n, // Serial port chip select, active low
  input wire logic serial_data_in, // Serial port data
  input wire logic [NUM_CH-1:0] data_in, // Fast data select per channel
  input wire logic [NUM_CH-1:0] receive_mode_in, // Fast receive select
  input wire logic [NUM_CH-1:0] high_level_input, // High drive level
  input wire logic [NUM_CH-1:0] low_level_input, // Low drive level
  input wire logic [NUM_CH-1:0] term_level_input, // Termination level
  input wire logic [NUM_CH-1:0] pin_output_in, // Level seen on pin
  input wire logic error_clear, // Clears the length error flag
  output logic [NUM_CH-1:0] pin_output_out, // Level driven to pin
  output logic [NUM_CH-1:0] pin_output_oe, // Pin drive enable
  output drive_mode_t [NUM_CH-1:0] chan_mode, // Current channel mode
  output chan_ctrl_t [NUM_CH-1:0] chan_ctrl, // Stored channel bits
  output logic [NUM_CH-1:0] pin_level_seen, // Synchronised pin level
  output ctrl_word_t latched_word, // Last word taken from shifter
  output logic [`WORD_W-1:0] frame_bit_count, // Bits in last frame
  output logic frame_len_error, // Sticky: a frame was not 8 bits
  output logic word_applied, // Pulse: a word reached the latches
  output logic [APPLY_COUNT_W-1:0] applied_count // Words applied
);
  // ==========================================================
  // Elaboration checks
  if (NUM_CH != `CHAN_COUNT) begin : g_bad_ch
    $error("pin_driver_mode_control serves exactly four channels");
  end
  if (APPLY_COUNT_W < 1) begin : g_bad_cnt
    $error("pin_driver_mode_control needs a counter width of one or more");
  end
  if (`SYNC_STAGES != 2) begin : g_bad_sync
    $error("pin_driver_mode_control crosses with exactly two flops");
  end

  // ==========================================================
  // Declarations
  logic [`WORD_W-1:0] shift_reg;
  logic [`WORD_W-1:0] edge_count;
  logic select_sync;
  logic select_prev;
  logic select_rise;
  logic select_fall;
  logic [`WORD_W-1:0] start_count;
  logic [`WORD_W-1:0] next_bits;
  logic load_pending;
  logic length_bad;
  logic apply_load;
  logic [NUM_CH-1:0] chan_write_en;
  fast_in_t fast_raw;
  fast_in_t fast;
  logic ctrl_rst_n;
  drive_mode_t [NUM_CH-1:0] next_mode;

  // ==========================================================
  // Decoding helpers

  // Mode from the stored bits and the fast inputs
  function automatic drive_mode_t decode_mode(
    input logic low_leak,
    input logic receive,
    input logic data,
    input logic term
  );
    drive_mode_t mode;
    mode = MODE_LOW_LEAK;
    if (low_leak) begin
      mode = MODE_LOW_LEAK;
    end else if (!receive) begin
      mode = data ? MODE_DRIVE_HIGH : MODE_DRIVE_LOW;
    end else begin
      mode = term ? MODE_TERMINATE : MODE_HIGH_Z;
    end
    return mode;
  endfunction

  // Level that a mode puts on the pin
  function automatic logic pick_level(
    input drive_mode_t mode,
    input logic hi,
    input logic lo,
    input logic tm
  );
    logic level;
    level = 1'b0;
    unique case (mode)
      MODE_DRIVE_HIGH: level = hi;
      MODE_DRIVE_LOW: level = lo;
      MODE_TERMINATE: level = tm;
      MODE_HIGH_Z: level = 1'b0;
      MODE_LOW_LEAK: level = 1'b0;
      default: level = 1'b0;
    endcase
    return level;
  endfunction

  // Whether a mode drives the pin at all
  function automatic logic drives_pin(input drive_mode_t mode);
    return (mode == MODE_DRIVE_HIGH) || (mode == MODE_DRIVE_LOW) ||
           (mode == MODE_TERMINATE);
  endfunction

  // Channel enables in channel order, channel one at index zero
  function automatic logic [NUM_CH-1:0] word_enables(input ctrl_word_t w);
    return {w.chan4_write_en, w.chan3_write_en, w.chan2_write_en,
            w.chan1_write_en};
  endfunction

  // ==========================================================
  // Serial clock domain

  // Shift register, only while select is low
  // System side reads it only once select is high and this clock stands
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `WORD_RST;
    end else if (!select_n) begin
      shift_reg <= {shift_reg[`WORD_W-2:0], serial_data_in};
    end
  end

  // Free-running edge count, frozen while select is high
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_count <= `COUNT_RST;
    end else if (!select_n) begin
      edge_count <= edge_count + 8'h01;
    end
  end

  // ==========================================================
  // Crossing into the system clock domain

  // Chip select level
  bit_sync #(
    .WIDTH(1),
    .RESET_VAL(`CS_IDLE)
  ) u_select_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(select_n),
    .sync_out(select_sync)
  );

  // Fast per-channel pin inputs
  assign fast_raw = '{data_in: data_in,
                      receive_mode_in: receive_mode_in,
                      high_level_input: high_level_input,
                      low_level_input: low_level_input,
                      term_level_input: term_level_input,
                      pin_output_in: pin_output_in};

  bit_sync #(
    .WIDTH($bits(fast_in_t)),
    .RESET_VAL(1'b0)
  ) u_fast_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(fast_raw),
    .sync_out(fast)
  );

  // Select edge detect on the synchronised level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      select_prev <= `CS_IDLE;
    end else begin
      select_prev <= select_sync;
    end
  end

  // Edges of the synchronised select, one cycle each
  assign select_rise = select_sync && !select_prev;
  assign select_fall = !select_sync && select_prev;

  // Edge count at frame start; stable since the serial clock is idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_count <= `COUNT_RST;
    end else if (select_fall) begin
      start_count <= edge_count;
    end
  end

  // Bits in the running frame, modulo 256
  assign next_bits = edge_count - start_count;

  // ==========================================================
  // Word capture at the end of a frame

  // Shifter read once select is high and the serial clock has stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latched_word <= `WORD_RST;
    end else if (select_rise) begin
      latched_word <= shift_reg;
    end
  end

  // Bits counted in the last frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_bit_count <= `COUNT_RST;
    end else if (select_rise) begin
      frame_bit_count <= next_bits;
    end
  end

  // Apply one cycle after capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_pending <= 1'b0;
    end else begin
      load_pending <= select_rise;
    end
  end

  // Frame length against the command word width
  assign length_bad = (frame_bit_count != `FRAME_BITS);

  // Strict option drops misaligned words
  assign apply_load = load_pending && !(STRICT_LENGTH && length_bad);

  // Sticky length error; a new error wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_len_error <= 1'b0;
    end else if (load_pending && length_bad) begin
      frame_len_error <= 1'b1;
    end else if (error_clear) begin
      frame_len_error <= 1'b0;
    end
  end

  // Word applied pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_applied <= 1'b0;
    end else begin
      word_applied <= apply_load;
    end
  end

  // Count of words applied, wrapping
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      applied_count <= '0;
    end else if (apply_load) begin
      applied_count <= applied_count + 1'b1;
    end
  end

  // ==========================================================
  // Channel latches

  // Unused bits D2 and D1 are carried in the word but never routed
  assign chan_write_en = word_enables(latched_word);
  assign ctrl_rst_n = rst_n && por_n;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    // Same word into every enabled channel
    chan_latch u_latch (
      .clock(clock),
      .rst_n(ctrl_rst_n),
      .por_n(por_n),
      .load(apply_load),
      .write_en(chan_write_en[c]),
      .word(latched_word),
      .ctrl(chan_ctrl[c])
    );

    // Mode from stored bits and fast inputs
    assign next_mode[c] = decode_mode(chan_ctrl[c].low_leak_sel,
                                      fast.receive_mode_in[c],
                                      fast.data_in[c],
                                      chan_ctrl[c].term_sel);
  end

  // ==========================================================
  // Output stage

  // Registered mode, low-leak after reset
  always_ff @(posedge clock or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        chan_mode[c] <= MODE_LOW_LEAK;
      end
    end else begin
      chan_mode <= next_mode;
    end
  end

  // Registered pin level and enable
  // High impedance and low-leak both release the pin; chan_mode tells them apart
  always_ff @(posedge clock or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      pin_output_out <= '0;
      pin_output_oe <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        pin_output_out[c] <= pick_level(next_mode[c],
                                        fast.high_level_input[c],
                                        fast.low_level_input[c],
                                        fast.term_level_input[c]);
        pin_output_oe[c] <= drives_pin(next_mode[c]);
      end
    end
  end

  // Pin level seen back, for monitoring
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_seen <= '0;
    end else begin
      pin_level_seen <= fast.pin_output_in;
    end
  end
endmodule

// ===== rtl/pin_driver_consts.svh
// Constants for the quad pin driver mode control block
`ifndef PIN_DRIVER_CONSTS_SVH
`define PIN_DRIVER_CONSTS_SVH
// ==========================================================
// Command word layout
`define WORD_W 8
`define CHAN_COUNT 4
`define EN_MSB 7
`define EN_LSB 4
`define LOW_LEAK_BIT 3
`define UNUSED_MSB 2
`define UNUSED_LSB 1
`define TERM_BIT 0
// ==========================================================
// Reset and power-up values
`define LOW_LEAK_RST 1'b1
`define TERM_RST 1'b0
`define WORD_RST 8'h00
`define COUNT_RST 8'h00
`define CS_IDLE 1'b1
// ==========================================================
// Frame and crossing figures
`define FRAME_BITS 8'h08
`define SYNC_STAGES 2
`endif

// ===== rtl/pin_driver_pkg.sv
// Types shared by the pin driver mode control design
package pin_driver_pkg;
  `include "pin_driver_consts.svh"

  // ==========================================================
  // Serial command word, first bit shifted in at the top
  typedef struct packed {
    logic chan1_write_en;
    logic chan2_write_en;
    logic chan3_write_en;
    logic chan4_write_en;
    logic low_leak_sel;
    logic [1:0] unused_bits;
    logic term_sel;
  } ctrl_word_t;

  // ==========================================================
  // Stored control bits of one channel
  typedef struct packed {
    logic low_leak_sel;
    logic term_sel;
  } chan_ctrl_t;

  // ==========================================================
  // Output state of one driver channel
  typedef enum logic [2:0] {
    MODE_DRIVE_HIGH = 3'b000,
    MODE_DRIVE_LOW = 3'b001,
    MODE_TERMINATE = 3'b010,
    MODE_HIGH_Z = 3'b011,
    MODE_LOW_LEAK = 3'b100
  } drive_mode_t;

  // ==========================================================
  // Fast per-channel pin inputs after synchronising
  typedef struct packed {
    logic [`CHAN_COUNT-1:0] data_in;
    logic [`CHAN_COUNT-1:0] receive_mode_in;
    logic [`CHAN_COUNT-1:0] high_level_input;
    logic [`CHAN_COUNT-1:0] low_level_input;
    logic [`CHAN_COUNT-1:0] term_level_input;
    logic [`CHAN_COUNT-1:0] pin_output_in;
  } fast_in_t;
endpackage

// ===== rtl/bit_sync.sv
// Two-flop synchroniser for a group of level signals
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Levels from another domain
  output logic [WIDTH-1:0] sync_out // Levels safe to use on clock
);
  logic [WIDTH-1:0] meta;

  // ==========================================================
  // Elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("bit_sync needs a width of one or more");
  end

  // First stage, read by the second stage only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{RESET_VAL}};
    end else begin
      meta <= async_in;
    end
  end

  // Second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      sync_out <= meta;
    end
  end
endmodule

// ===== rtl/chan_latch.sv
// Control latch of one driver channel
module chan_latch
  import pin_driver_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Low-leak set, active low, asynchronous
  input wire logic por_n, // Power-up clear, active low, asynchronous
  input wire logic load, // One-cycle word apply strobe
  input wire logic write_en, // This channel is enabled in the word
  input wire ctrl_word_t word, // Latched command word
  output chan_ctrl_t ctrl // Stored control bits
);
  logic low_leak; // Stored low-leak select
  logic term; // Stored termination select

  // Low-leak select: forced to one by either reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_leak <= `LOW_LEAK_RST;
    end else if (load && write_en) begin
      low_leak <= word.low_leak_sel;
    end
  end

  // Termination select: cleared at power-up only, kept through rst_n
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      term <= `TERM_RST;
    end else if (load && write_en) begin
      term <= word.term_sel;
    end
  end

  // Both bits out as one word; each bit keeps a single writing process
  assign ctrl = '{low_leak_sel: low_leak, term_sel: term};
endmodule

// ===== dv/pin_driver_checker_assertions.sv
// Port checker for the pin driver mode control block
module pin_driver_checker
  import pin_driver_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int APPLY_COUNT_W = 16
) (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire logic por_n, // Power-up reset
  input wire logic select_n, // Chip select
  input wire logic [NUM_CH-1:0] data_in, // Data select
  input wire logic [NUM_CH-1:0] receive_mode_in, // Receive select
  input wire logic [NUM_CH-1:0] pin_output_oe, // Drive enable
  input wire drive_mode_t [NUM_CH-1:0] chan_mode, // Modes
  input wire chan_ctrl_t [NUM_CH-1:0] chan_ctrl, // Stored bits
  input wire ctrl_word_t latched_word, // Last word
  input wire logic [7:0] frame_bit_count, // Frame length
  input wire logic frame_len_error, // Length flag
  input wire logic word_applied, // Apply pulse
  input wire logic [APPLY_COUNT_W-1:0] applied_count // Apply count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Common clock and reset
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n || !por_n);
  // Per-channel mode selection and update masking
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    low_leak_wins_a: assert property (
      $past(chan_ctrl[i].low_leak_sel) |-> chan_mode[i] == MODE_LOW_LEAK)
      else $error("low-leak channel not in low-leak mode");
    drive_follows_a: assert property (
      !$past(chan_ctrl[i].low_leak_sel) && !$past(receive_mode_in[i], 3) |->
      chan_mode[i] == ($past(data_in[i], 3) ? MODE_DRIVE_HIGH : MODE_DRIVE_LOW))
      else $error("drive mode does not follow data");
    receive_mode_a: assert property (
      !$past(chan_ctrl[i].low_leak_sel) && $past(receive_mode_in[i], 3) |->
      chan_mode[i] == ($past(chan_ctrl[i].term_sel) ? MODE_TERMINATE : MODE_HIGH_Z))
      else $error("receive mode wrong");
    enable_matches_a: assert property (
      pin_output_oe[i] == (chan_mode[i] inside {MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_TERMINATE}))
      else $error("drive enable disagrees with mode");
    masked_update_a: assert property (
      $changed(chan_ctrl[i]) |-> latched_word[7-i] &&
      chan_ctrl[i] == {latched_word.low_leak_sel, latched_word.term_sel})
      else $error("channel bits changed without enable");
  end
  // Frame apply sequencing
  apply_pulse_a: assert property (word_applied |=> !word_applied)
    else $error("apply pulse longer than one cycle");
  select_rise_apply_a: assert property ($rose(select_n) |-> ##[2:8] word_applied)
    else $error("no apply after select rise");
  count_step_a: assert property (
    $changed(applied_count) |-> applied_count == $past(applied_count) + 1'b1 &&
    (word_applied || $past(word_applied)))
    else $error("apply count stepped wrongly");
  short_frame_a: assert property ($rose(frame_len_error) |-> frame_bit_count != 8'h08)
    else $error("length flag on an eight bit frame");
endmodule
bind pin_driver_mode_control pin_driver_checker #(.NUM_CH(NUM_CH),
  .APPLY_COUNT_W(APPLY_COUNT_W)) u_chk (
  .clock(clock), .rst_n(rst_n), .por_n(por_n), .select_n(select_n), .data_in(data_in),
  .receive_mode_in(receive_mode_in), .pin_output_oe(pin_output_oe), .chan_mode(chan_mode),
  .chan_ctrl(chan_ctrl), .latched_word(latched_word), .frame_bit_count(frame_bit_count),
  .frame_len_error(frame_len_error), .word_applied(word_applied),
  .applied_count(applied_count));

// ===== dv/serial_ctl_model.sv
// Serial controller model for the three-wire command port
module serial_ctl_model (
  output logic serial_clock, // Link clock, still between frames except when stray_clocks pulses it
  output logic select_n, // Chip select, active low
  output logic serial_data_in // Command data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Idle levels
  initial begin
    serial_clock = 1'b0;
    select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Frame of nbits, top bit first, data moved while the clock is low
  task automatic send(input logic [7:0] word, input int nbits);
    #3 select_n = 1'b0;
    #40;
    for (int k = nbits - 1; k >= 0; k--) begin
      serial_data_in = word[k % 8];
      #32 serial_clock = 1'b1;
      #32 serial_clock = 1'b0;
    end
    #40 select_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
  // Clock pulses with select high
  task automatic stray_clocks(input int n);
    repeat (n) begin
      #32 serial_clock = 1'b1;
      #32 serial_clock = 1'b0;
    end
  endtask
endmodule

// ===== dv/pin_driver_mode_control_tb.sv
// Self-checking bench for the pin driver mode control block
module pin_driver_mode_control_tb
  import pin_driver_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, por_n, error_clear, serial_clock, select_n, serial_data_in;
  logic [3:0] data_in, receive_mode_in, high_level_input, low_level_input, term_level_input;
  logic [3:0] pin_output_in, pin_output_out, pin_output_oe, pin_level_seen;
  logic frame_len_error, word_applied;
  logic [7:0] frame_bit_count;
  logic [15:0] applied_count;
  drive_mode_t [3:0] chan_mode;
  chan_ctrl_t [3:0] chan_ctrl, exp_ctrl;
  ctrl_word_t latched_word;
  logic [31:0] seed;
  int miscompares, checks, applied;
  logic [7:0] corner [5] = '{8'hf0, 8'h86, 8'h0f, 8'h58, 8'hf1};
  // ==========
  // Clock and units
  initial clock = 1'b0;
  always #4 clock = ~clock;
  pin_driver_mode_control u_dut (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .serial_clock(serial_clock),
    .select_n(select_n), .serial_data_in(serial_data_in), .data_in(data_in),
    .receive_mode_in(receive_mode_in), .high_level_input(high_level_input),
    .low_level_input(low_level_input), .term_level_input(term_level_input),
    .pin_output_in(pin_output_in), .error_clear(error_clear),
    .pin_output_out(pin_output_out), .pin_output_oe(pin_output_oe), .chan_mode(chan_mode),
    .chan_ctrl(chan_ctrl), .pin_level_seen(pin_level_seen), .latched_word(latched_word),
    .frame_bit_count(frame_bit_count), .frame_len_error(frame_len_error),
    .word_applied(word_applied), .applied_count(applied_count));
  serial_ctl_model u_ctl (.serial_clock(serial_clock), .select_n(select_n),
    .serial_data_in(serial_data_in));
  // ==========
  // Expectations and compares
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic drive_mode_t exp_mode(input chan_ctrl_t c, input logic r, input logic d);
    if (c.low_leak_sel) return MODE_LOW_LEAK;
    if (!r) return d ? MODE_DRIVE_HIGH : MODE_DRIVE_LOW;
    return c.term_sel ? MODE_TERMINATE : MODE_HIGH_Z;
  endfunction
  task automatic cmp_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_mode(input string what, input drive_mode_t exp, input drive_mode_t got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_chans();
    drive_mode_t em;
    for (int i = 0; i < 4; i++) begin
      em = exp_mode(exp_ctrl[i], receive_mode_in[i], data_in[i]);
      cmp_vec("chan_ctrl", 16'(exp_ctrl[i]), 16'(chan_ctrl[i]));
      cmp_mode("chan_mode", em, chan_mode[i]);
      cmp_vec("pin_output_oe", 16'(em < MODE_HIGH_Z), 16'(pin_output_oe[i]));
      cmp_vec("pin_output_out", 16'(em == MODE_DRIVE_HIGH ? high_level_input[i] :
        em == MODE_DRIVE_LOW ? low_level_input[i] : em == MODE_TERMINATE &&
        term_level_input[i]), 16'(pin_output_out[i]));
    end
  endtask
  // Random fast inputs, then a settled look at every channel
  task automatic shake_inputs();
    @(posedge clock);
    seed = xorshift(seed);
    data_in <= seed[3:0];
    receive_mode_in <= seed[7:4];
    high_level_input <= seed[11:8];
    low_level_input <= seed[15:12];
    term_level_input <= seed[19:16];
    pin_output_in <= seed[23:20];
    repeat (4) @(posedge clock);
    @(negedge clock);
    check_chans();
    cmp_vec("pin_level_seen", 16'(pin_output_in), 16'(pin_level_seen));
  endtask
  // One frame, wait for its apply pulse, then compare
  task automatic do_word(input logic [7:0] w, input int nbits);
    int n;
    if (nbits != 8) w[7] = 1'b0;
    u_ctl.send(w, nbits);
    n = 0;
    while (word_applied !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    cmp_vec("word_applied", 16'h1, 16'(word_applied));
    repeat (3) @(negedge clock);
    applied++;
    for (int i = 0; i < 4; i++) begin
      if (w[7-i]) exp_ctrl[i] = {w[3], w[0]};
    end
    cmp_vec("latched_word", 16'(w), 16'(latched_word));
    cmp_vec("frame_bit_count", 16'(nbits), 16'(frame_bit_count));
    cmp_vec("applied_count", 16'(applied), applied_count);
    check_chans();
  endtask
  // ==========
  // Main sequence
  initial begin
    seed = 32'h3050a7c8;
    {rst_n, por_n, error_clear, data_in, receive_mode_in} = '0;
    {high_level_input, low_level_input, term_level_input, pin_output_in} = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(negedge clock);
    exp_ctrl = {4{2'b10}};
    check_chans();
    cmp_vec("applied_count", 16'h0, applied_count);
    $display("test reset_values done");
    foreach (corner[k]) begin
      do_word(corner[k], 8);
      shake_inputs();
    end
    repeat (10) begin
      seed = xorshift(seed);
      do_word(seed[7:0], 8);
      shake_inputs();
    end
    $display("test words done");
    u_ctl.stray_clocks(8);
    repeat (8) @(negedge clock);
    cmp_vec("applied_count", 16'(applied), applied_count);
    do_word(8'h18, 8);
    do_word(8'h4e, 7);
    cmp_vec("frame_len_error", 16'h1, 16'(frame_len_error));
    @(posedge clock);
    error_clear <= 1'b1;
    @(posedge clock);
    error_clear <= 1'b0;
    @(negedge clock);
    cmp_vec("frame_len_error", 16'h0, 16'(frame_len_error));
    $display("test framing done");
    do_word(8'hf1, 8);
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    for (int i = 0; i < 4; i++) exp_ctrl[i].low_leak_sel = 1'b1;
    check_chans();
    @(posedge clock);
    rst_n <= 1'b1;
    applied = 0;
    repeat (3) @(negedge clock);
    check_chans();
    do_word(8'h80, 8);
    shake_inputs();
    $display("test reset_midrun done");
    final_report();
  end
  // Hang guard
  initial begin
    #200us;
    miscompares++;
    final_report();
  end
endmodule
